// ---- vic_pkg.sv ----
// constants shared by the vectored interrupt control block
package vic_pkg;

    // ------------------------------------------------------------
    // vector and source structure
    // ------------------------------------------------------------
    localparam int NUM_VEC = 16;
    localparam int NUM_MASK = 15;
    localparam int NUM_SEL = 8;
    localparam logic [3:0] VEC_RESET = 4'h0;
    localparam logic [3:0] VEC_BRK = 4'hf;
    // shared vectors per variant, one bit per maskable request
    localparam logic [14:0] SHARED_BUS = 15'h6f09;
    localparam logic [14:0] SHARED_BASE = 15'h6601;
    // which source selection bit steers each maskable request
    localparam logic [2:0] SEL_OF [15] = '{3'h0, 3'h0, 3'h0, 3'h1,
        3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h6,
        3'h7};

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_REQ = 12'h000;
    localparam logic [11:0] ADDR_EN = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;
    localparam logic [11:0] ADDR_SCLR = 12'h00c;
    localparam logic [11:0] ADDR_SIEN = 12'h010;
    localparam logic [11:0] ADDR_VEC = 12'h014;
    localparam logic [9:0] IDX_SRCSEL = 10'h039;
    localparam logic [11:0] ADDR_SRCSEL = {IDX_SRCSEL, 2'b00};

    // ------------------------------------------------------------
    // reset values and status fields
    // ------------------------------------------------------------
    localparam logic [14:0] EN_RST = 15'h0000;
    localparam logic [7:0] SRCSEL_RST = 8'h00;
    localparam logic [2:0] SIEN_RST = 3'h0;
    localparam int ST_ACCEPT = 0;
    localparam int ST_LOST = 1;
    localparam int ST_BRK = 2;

endpackage

// ---- vic_req_bits.sv ----
// latched request bits, one per maskable vector
`timescale 1ns/10ps
`default_nettype none
module vic_req_bits
    import vic_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [14:0] evt_pri,
    input wire logic [14:0] evt_alt,
    input wire logic [7:0] src_sel,
    input wire logic [14:0] shared_mask,
    input wire logic sw_we,
    input wire logic [14:0] sw_wdata,
    input wire logic [14:0] ack_clr,
    output logic [14:0] req,
    output logic [14:0] lost
);
    // ------------------------------------------------------------
    // per request bit
    // ------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < NUM_MASK; k = k + 1) begin : g_req
            wire use_alt;
            wire evt;
            wire clr;
            logic req_r;
            assign use_alt = shared_mask[k] & src_sel[SEL_OF[k]];
            assign evt = use_alt ? evt_alt[k] : evt_pri[k];
            // a written zero or an acceptance clears; a written one is ignored
            assign clr = (sw_we & ~sw_wdata[k]) | ack_clr[k];
            assign lost[k] = evt & req_r;
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    req_r <= 1'b0;
                end else if (evt) begin
                    req_r <= 1'b1;
                end else if (clr) begin
                    req_r <= 1'b0;
                end
            end
            assign req[k] = req_r;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- vic_prio.sv ----
// fixed priority selection among pending vectors
`timescale 1ns/10ps
`default_nettype none
module vic_prio
    import vic_pkg::*;
(
    input wire logic rst_pend,
    input wire logic brk_pend,
    input wire logic [14:0] qual,
    output logic any,
    output logic [3:0] vec
);
    // ------------------------------------------------------------
    // lowest vector number wins
    // ------------------------------------------------------------
    always_comb begin
        vec = VEC_BRK;
        for (int i = NUM_MASK - 1; i >= 0; i = i - 1) begin
            if (qual[i]) begin
                vec = 4'(i + 1);
            end
        end
        if (rst_pend) begin
            vec = VEC_RESET;
        end
        any = rst_pend | brk_pend | (|qual);
    end
endmodule
`default_nettype wire

// ---- vic_top.sv ----
// vectored interrupt control: request gating, priority, apb registers
// Overview of operation
// - maskable needs request, enable set, disable clear
// - enable bits freely set and cleared
// - writing 0 clears request, 1 ignored
// - reset and break never masked
// - disable flag blocks all but reset, break
// - break bypasses request, enable, disable flag
// - simultaneous requests served by fixed priority
// - bus variant: 23 sources onto 16 vectors
// - base variant: 20 sources onto 16 vectors
// - acceptance clears the served request bit
// - source selection picks each shared pair
// - reset is the highest priority vector
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module vic_top
    import vic_pkg::*;
#(
    parameter bit BUS_VARIANT = 1'b1
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [14:0] evt_pri,
    input wire logic [14:0] evt_alt,
    input wire logic software_break_instruction,
    input wire logic int_disable,
    input wire logic irq_ack,
    output logic irq_req,
    output logic [3:0] irq_vec,
    output logic irq_out
);
    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc;
    wire wr;
    wire hit_req;
    wire hit_en;
    wire hit_stat;
    wire hit_sclr;
    wire hit_sien;
    wire hit_vec;
    wire hit_sel;
    wire mapped;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign hit_req = (paddr == ADDR_REQ);
    assign hit_en = (paddr == ADDR_EN);
    assign hit_stat = (paddr == ADDR_STAT);
    assign hit_sclr = (paddr == ADDR_SCLR);
    assign hit_sien = (paddr == ADDR_SIEN);
    assign hit_vec = (paddr == ADDR_VEC);
    assign hit_sel = (paddr == ADDR_SRCSEL);
    assign mapped = hit_req | hit_en | hit_stat | hit_sclr | hit_sien
        | hit_vec | hit_sel;
    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [14:0] en_r;
    logic [7:0] srcsel_r;
    logic [2:0] sien_r;
    logic [2:0] stat_r;
    logic [2:0] stat_nxt;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    wire [14:0] shared_mask;
    wire [14:0] req;
    wire [14:0] lost;
    wire [14:0] ack_clr;
    wire [14:0] qual;
    wire sw_req_we;
    wire any;
    wire [3:0] sel_vec;

    // variant decides which vectors are shared pairs
    assign shared_mask = BUS_VARIANT ? SHARED_BUS : SHARED_BASE;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            en_r <= EN_RST;
            srcsel_r <= SRCSEL_RST;
            sien_r <= SIEN_RST;
        end else begin
            if (wr & hit_en) begin
                en_r <= pwdata[14:0];
            end
            if (wr & hit_sel) begin
                srcsel_r <= pwdata[7:0];
            end
            if (wr & hit_sien) begin
                sien_r <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // request bits
    // ------------------------------------------------------------
    // reselecting a pair can produce a stray event; software is
    // expected to clear it with interrupts disabled
    assign sw_req_we = wr & hit_req;

    vic_req_bits u_req (
        .core_clk(core_clk),
        .reset(reset),
        .evt_pri(evt_pri),
        .evt_alt(evt_alt),
        .src_sel(srcsel_r),
        .shared_mask(shared_mask),
        .sw_we(sw_req_we),
        .sw_wdata(pwdata[14:0]),
        .ack_clr(ack_clr),
        .req(req),
        .lost(lost)
    );

    // ------------------------------------------------------------
    // unmaskable sources
    // ------------------------------------------------------------
    logic rst_pend_r;
    logic brk_pend_r;
    wire ack_rst;
    wire ack_brk;
    assign ack_rst = irq_ack & (irq_vec == VEC_RESET) & rst_pend_r;
    assign ack_brk = irq_ack & (irq_vec == VEC_BRK) & brk_pend_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rst_pend_r <= 1'b1;
            brk_pend_r <= 1'b0;
        end else begin
            if (ack_rst) begin
                rst_pend_r <= 1'b0;
            end
            // the break goes straight to pending, no gating at all
            if (software_break_instruction) begin
                brk_pend_r <= 1'b1;
            end else if (ack_brk) begin
                brk_pend_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // qualification and priority
    // ------------------------------------------------------------
    assign qual = req & en_r & {NUM_MASK{~int_disable}};

    vic_prio u_prio (
        .rst_pend(rst_pend_r),
        .brk_pend(brk_pend_r),
        .qual(qual),
        .any(any),
        .vec(sel_vec)
    );

    // ------------------------------------------------------------
    // presentation to the core
    // ------------------------------------------------------------
    logic req_r;
    logic [3:0] vec_r;
    // the served bit clears one cycle after the ack, so the request
    // is dropped for that cycle to avoid serving it twice
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_r <= 1'b0;
            vec_r <= VEC_RESET;
        end else begin
            req_r <= any & ~irq_ack;
            vec_r <= sel_vec;
        end
    end
    assign irq_req = req_r;
    assign irq_vec = vec_r;

    genvar g;
    generate
        for (g = 0; g < NUM_MASK; g = g + 1) begin : g_ack
            assign ack_clr[g] = irq_ack & req_r
                & (vec_r == 4'(g + 1));
        end
    endgenerate

    // ------------------------------------------------------------
    // block status and interrupt line
    // ------------------------------------------------------------
    wire sclr_we;
    assign sclr_we = wr & hit_sclr;
    always_comb begin
        stat_nxt = stat_r;
        if (sclr_we) begin
            stat_nxt = stat_r & ~pwdata[2:0];
        end
        // a new event in the clearing cycle survives the clear
        if (irq_ack & req_r) begin
            stat_nxt[ST_ACCEPT] = 1'b1;
        end
        if (|lost) begin
            stat_nxt[ST_LOST] = 1'b1;
        end
        if (software_break_instruction) begin
            stat_nxt[ST_BRK] = 1'b1;
        end
    end

    logic irq_out_r;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stat_r <= 3'h0;
            irq_out_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_out_r <= |(stat_nxt & sien_r);
        end
    end
    assign irq_out = irq_out_r;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_req) begin
            rd_nxt = {17'h0_0000, req};
        end else if (hit_en) begin
            rd_nxt = {17'h0_0000, en_r};
        end else if (hit_stat) begin
            rd_nxt = {29'h0000_0000, stat_r};
        end else if (hit_sien) begin
            rd_nxt = {29'h0000_0000, sien_r};
        end else if (hit_vec) begin
            rd_nxt = {26'h000_0000, rst_pend_r, req_r, vec_r};
        end else if (hit_sel) begin
            rd_nxt = {24'h00_0000, srcsel_r};
        end
    end
    // setup-phase capture so the access phase shows stable data
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_r <= rd_nxt;
        end
    end
    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // index by the vector shown now; qualifiers are last cycle's
    property p_mask_gate;
        irq_req && irq_vec != VEC_RESET && irq_vec != VEC_BRK
            |-> ((($past(req) & $past(en_r)) >> (irq_vec - 4'h1))
            & 15'h0001) == 15'h0001 && !$past(int_disable);
    endproperty
    a_mask_gate: assert property (p_mask_gate)
        else $error("maskable vector served without qualification");

    property p_en_write;
        wr && hit_en |=> en_r == $past(pwdata[14:0]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable register did not take write");

    property p_req_one_ignored;
        wr && hit_req && (&pwdata[14:0]) && !(|evt_pri) && !(|evt_alt)
            && !irq_ack |=> req == $past(req);
    endproperty
    a_req_one_ignored: assert property (p_req_one_ignored)
        else $error("writing ones changed request bits");

    property p_brk_unmasked;
        software_break_instruction && !rst_pend_r && !(|qual)
            && !irq_ack |=> ##1 irq_req && irq_vec == VEC_BRK;
    endproperty
    a_brk_unmasked: assert property (p_brk_unmasked)
        else $error("break not presented");

    property p_disable_blocks;
        int_disable && !rst_pend_r && !brk_pend_r
            && !software_break_instruction ##1 int_disable |=> !irq_req;
    endproperty
    a_disable_blocks: assert property (p_disable_blocks)
        else $error("request raised while disabled");

    property p_reset_first;
        rst_pend_r ##1 rst_pend_r |-> irq_vec == VEC_RESET;
    endproperty
    a_reset_first: assert property (p_reset_first)
        else $error("reset vector not first");

    property p_ack_clears;
        irq_ack && req_r && vec_r != VEC_RESET && vec_r != VEC_BRK
            && !evt_pri[vec_r - 4'h1] && !evt_alt[vec_r - 4'h1]
            |=> !req[$past(vec_r) - 4'h1] ##1 1'b1;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("accepted request bit not cleared");

    property p_req_sticky;
        req[2] && !irq_ack && !(wr && hit_req) |=> req[2];
    endproperty
    a_req_sticky: assert property (p_req_sticky)
        else $error("request bit dropped on its own");

    property p_prio_order;
        irq_req && irq_vec != VEC_RESET && irq_vec != VEC_BRK
            |-> ($past(qual) & ((15'h0001 << (irq_vec - 4'h1))
            - 15'h0001)) == 15'h0000;
    endproperty
    a_prio_order: assert property (p_prio_order)
        else $error("lower priority vector served first");

    property p_req_zero_clears;
        wr && hit_req && !(|evt_pri) && !(|evt_alt) && !irq_ack
            |=> req == ($past(req) & $past(pwdata[14:0]));
    endproperty
    a_req_zero_clears: assert property (p_req_zero_clears)
        else $error("writing zeros did not clear request bits");

    property p_sel_pair;
        srcsel_r[0] && evt_alt[0] |=> req[0];
    endproperty
    a_sel_pair: assert property (p_sel_pair)
        else $error("selected alternate source did not set request");

    c_brk: cover property (software_break_instruction ##[1:4] irq_ack);
    c_masked: cover property (|(req & ~en_r));
    c_two_pending: cover property ($countones(qual) > 1);
    c_status_irq: cover property (irq_out ##1 (wr && hit_sclr));
endmodule
`default_nettype wire

// ---- vic_core_model.sv ----
// behavioural core that accepts vectored interrupt requests
`timescale 1ns/10ps
`default_nettype none
module vic_core_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic irq_req,
    input wire logic [3:0] irq_vec,
    input wire logic cli,
    input wire logic sei,
    input wire logic [3:0] wcyc,
    output logic irq_ack,
    output logic int_disable
);
    // ----------------------------------------
    // acceptance
    // ----------------------------------------
    logic [3:0] cnt;
    logic [3:0] taken [$];
    // the flag stays set after acceptance until the bench clears it
    always @(posedge core_clk) begin
        if (reset) begin
            irq_ack <= 1'b0;
            int_disable <= 1'b0;
            cnt <= 4'h0;
        end else begin
            irq_ack <= 1'b0;
            if (cli) begin
                int_disable <= 1'b0;
            end
            if (sei) begin
                int_disable <= 1'b1;
            end
            // ack only while a request is shown, never twice in a row
            if (irq_req && !irq_ack) begin
                if (cnt >= wcyc) begin
                    irq_ack <= 1'b1;
                    int_disable <= 1'b1;
                    taken.push_back(irq_vec);
                    cnt <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end else begin
                cnt <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test_vectored_interrupt_control.sv ----
// self-checking bench for the vectored interrupt control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module test_vectored_interrupt_control import vic_pkg::*;;
    logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, seed = 32'hf129;
    logic pready, pslverr, sbrk = 0, irq_ack, irq_req, irq_out, err;
    logic int_disable, cli = 0, sei = 0;
    logic [14:0] evt_pri = '0, evt_alt = '0, req_m = '0, en_m;
    logic [3:0] irq_vec, wcyc = '0;
    int errors = 0, compares = 0, cyc = 0;

    vic_top #(.BUS_VARIANT(1'b1)) u_dut (.core_clk(core_clk),
        .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt_pri(evt_pri), .evt_alt(evt_alt),
        .software_break_instruction(sbrk), .int_disable(int_disable),
        .irq_ack(irq_ack), .irq_req(irq_req), .irq_vec(irq_vec),
        .irq_out(irq_out));
    vic_core_model u_core (.core_clk(core_clk), .reset(reset),
        .irq_req(irq_req), .irq_vec(irq_vec), .cli(cli), .sei(sei),
        .wcyc(wcyc), .irq_ack(irq_ack), .int_disable(int_disable));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            complete_run();
        end
    end
    task complete_run;
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    function int low(input logic [14:0] v);
        int k;
        k = -1;
        for (int j = 14; j >= 0; j--) if (v[j]) k = j;
        return k;
    endfunction
    task idle(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // the slave answers when it likes; the wait ends once pready is high, the timeout bounds it
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task flag(input logic c);
        @(posedge core_clk);
        if (c) cli <= 1'b1; else sei <= 1'b1;
        @(posedge core_clk);
        cli <= 1'b0;
        sei <= 1'b0;
    endtask
    task take(input logic [3:0] e, input logic c);
        int n, t;
        n = u_core.taken.size();
        if (c) flag(1'b1);
        t = 0;
        while (u_core.taken.size() == n && t < 40) begin
            @(posedge core_clk);
            t++;
        end
        `CHK("taken", n + 1, u_core.taken.size())
        `CHK("vec", e, u_core.taken[n])
    endtask
    task drain;
        int k;
        k = low(req_m & en_m);
        while (k >= 0) begin
            take(4'(k + 1), 1'b1);
            req_m[k] = 1'b0;
            k = low(req_m & en_m);
        end
        flag(1'b1);
        idle(6);
        `CHK("idle", 1'b0, irq_req)
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        idle(12);
        reset <= 1'b0;
        take(VEC_RESET, 1'b0);
        rchk("en", ADDR_EN, {17'h0, EN_RST});
        rchk("sel", ADDR_SRCSEL, {24'h0, SRCSEL_RST});
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            en_m = seed[14:0] & 15'h3fff;
            wcyc <= seed[19:16];
            // mask first: leftover requests must not fire on new enables
            flag(1'b0);
            apb(1'b1, ADDR_EN, {17'h0, en_m});
            rchk("en", ADDR_EN, {17'h0, en_m});
            seed = xs(seed);
            @(posedge core_clk);
            evt_pri <= seed[14:0] & 15'h3fff;
            @(posedge core_clk);
            req_m = req_m | evt_pri;
            evt_pri <= '0;
            idle(4);
            `CHK("masked", 1'b0, irq_req)
            rchk("req", ADDR_REQ, {17'h0, req_m});
            apb(1'b1, ADDR_REQ, 32'h7fff);
            rchk("req1", ADDR_REQ, {17'h0, req_m});
            drain();
            seed = xs(seed);
            apb(1'b1, ADDR_REQ, {17'h0, seed[14:0]});
            req_m = req_m & seed[14:0];
            rchk("req0", ADDR_REQ, {17'h0, req_m});
        end
        apb(1'b1, ADDR_REQ, 32'h0);
        flag(1'b0);
        @(posedge core_clk);
        sbrk <= 1'b1;
        @(posedge core_clk);
        sbrk <= 1'b0;
        take(VEC_BRK, 1'b0);
        apb(1'b1, ADDR_SRCSEL, 32'h1);
        apb(1'b1, ADDR_REQ, 32'h0);
        @(posedge core_clk);
        evt_alt <= 15'h0001;
        @(posedge core_clk);
        evt_alt <= '0;
        rchk("alt", ADDR_REQ, 32'h1);
        apb(1'b1, ADDR_EN, 32'h1);
        take(4'h1, 1'b1);
        rchk("acc", ADDR_REQ, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK("st", 32'h5, rd & 32'h5)
        apb(1'b1, ADDR_SIEN, 32'h1);
        idle(2);
        `CHK("out", 1'b1, irq_out)
        apb(1'b1, ADDR_SCLR, 32'h7);
        idle(2);
        `CHK("out0", 1'b0, irq_out)
        rchk("bad", 12'h0f0, 32'h0);
        `CHK("slverr", 1'b1, err)
        complete_run();
    end
endmodule
`default_nettype wire
